// ==== logic/cfs_pkg.sv ====
`default_nettype none
package cfs_pkg;
   // Bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   // Data memory shape seen by the core
   localparam int SFR_COUNT = 128;
   localparam int GLOBAL_COUNT = 128;
   localparam int EXT_DATA_BYTES = 3840;
   // Register byte offsets
   localparam logic [7:0] A_WORK = 8'h00;
   localparam logic [7:0] A_OPND = 8'h04;
   localparam logic [7:0] A_CMD = 8'h08;
   localparam logic [7:0] A_COND = 8'h0c;
   localparam logic [7:0] A_PRODHI = 8'h10;
   localparam logic [7:0] A_SPEED = 8'h14;
   localparam logic [7:0] A_ISPEED = 8'h18;
   localparam logic [7:0] A_VECTOR = 8'h1c;
   localparam logic [7:0] A_APTR = 8'h20;
   localparam logic [7:0] A_DPTR = 8'h24;
   localparam logic [7:0] A_JUMP = 8'h28;
   localparam logic [7:0] A_CTRL = 8'h2c;
   // Command register fields
   localparam int CMD_OP_LSB = 0;
   localparam int CMD_IMM_LSB = 8;
   localparam int CMD_TGT_LSB = 16;
   localparam int TGT_W = 13;
   localparam int PAGE_W = 3;
   // Command codes
   localparam logic [3:0] OP_ADD = 4'h1;
   localparam logic [3:0] OP_SUB = 4'h2;
   localparam logic [3:0] OP_AND = 4'h3;
   localparam logic [3:0] OP_OR = 4'h4;
   localparam logic [3:0] OP_XOR = 4'h5;
   localparam logic [3:0] OP_MOVE = 4'h6;
   localparam logic [3:0] OP_ROT_RIGHT = 4'h7;
   localparam logic [3:0] OP_ROT_LEFT = 4'h8;
   localparam logic [3:0] OP_MUL_U = 4'h9;
   localparam logic [3:0] OP_MUL_S = 4'ha;
   localparam logic [3:0] OP_PAGE = 4'hb;
   localparam logic [3:0] OP_JUMP = 4'hc;
   localparam logic [3:0] OP_SPEED = 4'hd;
   localparam logic [3:0] OP_RETI = 4'he;
   // Condition status layout
   localparam int COND_PAGE_LSB = 5;
   localparam int COND_WDOG = 4;
   localparam int COND_LOWSUP = 3;
   localparam int COND_Z = 2;
   localparam int COND_DIGIT = 1;
   localparam int COND_CARRY = 0;
   localparam logic [7:0] COND_SW_MASK = 8'h07;
   // Speed setting layout; low nibble is not kept
   localparam int SPD_PLL_DIS = 7;
   localparam int SPD_XTAL_DIS = 6;
   localparam int SPD_SRC_LSB = 4;
   localparam logic [7:0] SPD_MASK = 8'hf0;
   localparam logic [7:0] SPD_RST = 8'h00;
   localparam logic [1:0] SRC_PLL = 2'b00;
   localparam logic [1:0] SRC_XTAL = 2'b01;
   localparam logic [1:0] SRC_SLOW = 2'b10;
   localparam logic [1:0] SRC_OFF = 2'b11;
   // Pin vector positions
   localparam int PIN_RSTN = 0;
   localparam int PIN_LSD = 1;
   localparam int PIN_IRQ_LSB = 2;
   localparam int CTRL_GIE = 0;
endpackage
`default_nettype wire

// ==== logic/cfs_alu.sv ====
`default_nettype none
module cfs_alu
   import cfs_pkg::*;
(
   // Operation
   input wire logic [3:0] op,
   input wire logic [7:0] acc,
   input wire logic [7:0] opnd,
   input wire logic carry_in,
   // Results
   output logic [7:0] res,
   output logic [7:0] hi,
   output logic w_we,
   output logic hi_we,
   // Flag updates
   output logic z_upd,
   output logic dc_upd,
   output logic c_upd,
   output logic zero,
   output logic dc,
   output logic carry
);
   logic [8:0] sum;
   logic [4:0] nib;
   logic [15:0] prod;

   // Working register is the usual source and destination
   always_comb begin
      sum = 9'h000;
      nib = 5'h00;
      prod = 16'h0000;
      res = acc;
      hi = 8'h00;
      w_we = 1'b0;
      hi_we = 1'b0;
      z_upd = 1'b0;
      dc_upd = 1'b0;
      c_upd = 1'b0;
      dc = 1'b0;
      carry = 1'b0;
      unique case (op)
         OP_ADD: begin
            sum = {1'b0, acc} + {1'b0, opnd};
            nib = {1'b0, acc[3:0]} + {1'b0, opnd[3:0]};
            res = sum[7:0];
            carry = sum[8];
            dc = nib[4];
            {w_we, z_upd, dc_upd, c_upd} = 4'hf;
         end
         OP_SUB: begin
            // Carry and digit carry read as "no borrow"
            sum = {1'b0, acc} - {1'b0, opnd};
            nib = {1'b0, acc[3:0]} - {1'b0, opnd[3:0]};
            res = sum[7:0];
            carry = ~sum[8];
            dc = ~nib[4];
            {w_we, z_upd, dc_upd, c_upd} = 4'hf;
         end
         OP_AND, OP_OR, OP_XOR, OP_MOVE: begin
            res = (op == OP_AND) ? (acc & opnd) :
                  (op == OP_OR) ? (acc | opnd) :
                  (op == OP_XOR) ? (acc ^ opnd) : opnd;
            {w_we, z_upd} = 2'b11;
         end
         OP_ROT_RIGHT: begin
            res = {carry_in, acc[7:1]};
            carry = acc[0];
            {w_we, c_upd} = 2'b11;
         end
         OP_ROT_LEFT: begin
            res = {acc[6:0], carry_in};
            carry = acc[7];
            {w_we, c_upd} = 2'b11;
         end
         OP_MUL_U, OP_MUL_S: begin
            if (op == OP_MUL_S) begin
               prod = 16'($signed({{8{acc[7]}}, acc})
                  * $signed({{8{opnd[7]}}, opnd}));
            end else begin
               prod = {8'h00, acc} * {8'h00, opnd};
            end
            res = prod[7:0];
            hi = prod[15:8];
            {w_we, hi_we} = 2'b11;
         end
         default: begin
         end
      endcase
      zero = (res == 8'h00);
   end
endmodule
`default_nettype wire

// ==== logic/cfs_core.sv ====
// Our own choices: register access over APB and the placing of the registers.
`default_nettype none
// Overview of operation
// - Zero flag set when an affecting result is zero, else cleared.
// - Digit carry: add carry out of bit 3; subtract no-borrow.
// - Carry: add carry out of bit 7; subtract no-borrow.
// - Rotate right loads carry with LSB, rotate left with MSB.
// - At each reset, watchdog cause flag shows watchdog overflow.
// - At each reset, brown-out cause flag shows low-supply detection.
// - Three page bits from page command extend 13-bit jump targets.
// - Multiply puts product high byte aside, low byte in working reg.
// - Speed setting read-only; changes on speed, interrupt, return.
// - Multiplier-disable bit set turns the clock multiplier off.
// - Crystal-disable bit stops oscillator and blocks its clock input.
// - Two-bit field picks the system clock source.
// - Source 00 multiplier, 01 crystal, 10 slow oscillator, 11 off.
// - Separate interrupt speed setting applies during interrupt service.
// - Reset comes from pin, power-on, brown-out, watchdog, debug.
// - Core works on 8-bit data in the documented memory shape.
// - Wide pointers are built from 8-bit register bytes.
// - Working register is the main operand of arithmetic.
// - One reprogrammable vector; peripherals and 8 pins interrupt.
module cfs_core
   import cfs_pkg::*;
#(
   parameter int EXT_IRQ_N = 8
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Reset sources
   input wire logic reset_pin_n,
   input wire logic low_supply_detect,
   input wire logic wdt_overflow,
   input wire logic debug_reset,
   output logic core_reset,
   // Interrupt sources
   input wire logic periph_irq,
   input wire logic [EXT_IRQ_N-1:0] ext_irq,
   output logic isr_active,
   // Jump address
   output logic [15:0] jump_addr,
   output logic jump_strobe,
   // Clock controls
   output logic pll_disable,
   output logic main_crystal_disable_bit,
   output logic primary_clock_block,
   output logic [1:0] system_source_select,
   output logic [3:0] source_onehot
);
   localparam int PIN_N = EXT_IRQ_N + PIN_IRQ_LSB;
   localparam logic [PIN_N-1:0] PIN_IDLE = PIN_N'(1);

   // Widths the logic is built around
   if (EXT_IRQ_N < 1 || EXT_IRQ_N > 8) begin : g_chk_irq
      $error("EXT_IRQ_N must be 1 to 8");
   end
   if (DATA_W != 8) begin : g_chk_data
      $error("core data is 8 bits wide");
   end

   typedef struct packed {
      logic [PIN_N-1:0] s1;
      logic [PIN_N-1:0] s2;
      logic [PIN_N-1:0] s3;
      logic [PIN_N-1:0] filt;
      logic core_rst;
      logic [7:0] work;
      logic [7:0] opnd;
      logic [7:0] prodhi;
      logic [7:0] cond;
      logic [7:0] spd;
      logic [7:0] ispd;
      logic [7:0] sh_cond;
      logic [7:0] sh_spd;
      logic [15:0] vec;
      logic [15:0] dptr;
      logic [23:0] aptr;
      logic [15:0] jaddr;
      logic jstb;
      logic in_isr;
      logic gie;
      logic [31:0] rdata;
   } cfs_state_s;

   cfs_state_s s_q;
   cfs_state_s s_d;

   logic [PIN_N-1:0] pin_raw;
   logic setup;
   logic wr;
   logic fire;
   logic [3:0] cmd_op;
   logic [7:0] cmd_imm;
   logic [TGT_W-1:0] cmd_tgt;
   logic rst_req;
   logic irq_any;
   logic take;
   logic [31:0] rd_val;
   logic [7:0] alu_res;
   logic [7:0] alu_hi;
   logic alu_w_we;
   logic alu_hi_we;
   logic alu_z_upd;
   logic alu_dc_upd;
   logic alu_c_upd;
   logic alu_zero;
   logic alu_dc;
   logic alu_carry;

   // Every printed register answers; anything else is an error
   function automatic logic cfs_mapped(input logic [ADDR_W-1:0] a);
      return a inside {A_WORK, A_OPND, A_CMD, A_COND, A_PRODHI,
         A_SPEED, A_ISPEED, A_VECTOR, A_APTR, A_DPTR, A_JUMP, A_CTRL};
   endfunction

   // Bus phases; zero wait states
   assign setup = psel & ~penable;
   assign wr = psel & penable & pwrite & cfs_mapped(paddr);
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~cfs_mapped(paddr);
   assign cmd_op = pwdata[CMD_OP_LSB +: 4];
   assign cmd_imm = pwdata[CMD_IMM_LSB +: 8];
   assign cmd_tgt = pwdata[CMD_TGT_LSB +: TGT_W];
   // Commands are dropped while the core is held in reset
   assign fire = wr & (paddr == A_CMD) & ~s_q.core_rst;

   // Asynchronous pins enter one shared synchroniser
   assign pin_raw = {ext_irq, low_supply_detect, reset_pin_n};
   // Any of the four sources holds the core in reset
   assign rst_req = ~s_q.filt[PIN_RSTN] | s_q.filt[PIN_LSD]
      | wdt_overflow | debug_reset;
   assign irq_any = periph_irq
      | (|s_q.filt[PIN_N-1:PIN_IRQ_LSB]);
   // An interrupt waits a cycle rather than race a command
   assign take = irq_any & s_q.gie & ~s_q.in_isr & ~fire
      & ~s_q.core_rst;

   cfs_alu u_alu (
      .op(fire ? cmd_op : 4'h0),
      .acc(s_q.work),
      .opnd(s_q.opnd),
      .carry_in(s_q.cond[COND_CARRY]),
      .res(alu_res),
      .hi(alu_hi),
      .w_we(alu_w_we),
      .hi_we(alu_hi_we),
      .z_upd(alu_z_upd),
      .dc_upd(alu_dc_upd),
      .c_upd(alu_c_upd),
      .zero(alu_zero),
      .dc(alu_dc),
      .carry(alu_carry)
   );

   // Read data, captured in the setup phase so prdata is a flop
   always_comb begin
      rd_val = 32'h0000_0000;
      unique case (paddr)
         A_WORK: rd_val[7:0] = s_q.work;
         A_OPND: rd_val[7:0] = s_q.opnd;
         A_COND: rd_val[7:0] = s_q.cond;
         A_PRODHI: rd_val[7:0] = s_q.prodhi;
         A_SPEED: rd_val[7:0] = s_q.spd;
         A_ISPEED: rd_val[7:0] = s_q.ispd;
         A_VECTOR: rd_val[15:0] = s_q.vec;
         A_APTR: rd_val[23:0] = s_q.aptr;
         A_DPTR: rd_val[15:0] = s_q.dptr;
         A_JUMP: rd_val[15:0] = s_q.jaddr;
         A_CTRL: rd_val[1:0] = {s_q.in_isr, s_q.gie};
         default: rd_val = 32'h0000_0000;
      endcase
   end

   // Next state of the whole block
   always_comb begin
      s_d = s_q;
      s_d.s1 = pin_raw;
      s_d.s2 = s_q.s1;
      s_d.s3 = s_q.s2;
      // A pin level counts only once two stages agree
      s_d.filt = (s_q.s2 & s_q.s3) | (s_q.filt & (s_q.s2 ^ s_q.s3));
      s_d.jstb = 1'b0;
      s_d.core_rst = rst_req;
      if (setup) begin
         s_d.rdata = rd_val;
      end
      if (rst_req) begin
         // Cause flags decided as the reset begins, merged while held
         if (!s_q.core_rst) begin
            s_d.cond[COND_WDOG] = wdt_overflow;
            s_d.cond[COND_LOWSUP] = s_q.filt[PIN_LSD];
         end else begin
            s_d.cond[COND_WDOG] = s_q.cond[COND_WDOG] | wdt_overflow;
            s_d.cond[COND_LOWSUP] = s_q.cond[COND_LOWSUP]
               | s_q.filt[PIN_LSD];
         end
         s_d.cond[COND_PAGE_LSB +: PAGE_W] = 3'h0;
         s_d.cond[COND_Z] = 1'b0;
         s_d.cond[COND_DIGIT] = 1'b0;
         s_d.cond[COND_CARRY] = 1'b0;
         s_d.work = 8'h00;
         s_d.opnd = 8'h00;
         s_d.prodhi = 8'h00;
         s_d.spd = SPD_RST;
         s_d.ispd = SPD_RST;
         s_d.sh_cond = 8'h00;
         s_d.sh_spd = SPD_RST;
         s_d.vec = 16'h0000;
         s_d.dptr = 16'h0000;
         s_d.aptr = 24'h00_0000;
         s_d.jaddr = 16'h0000;
         s_d.in_isr = 1'b0;
         s_d.gie = 1'b0;
      end else begin
         // Software writes; the speed setting has no write path
         if (wr) begin
            unique case (paddr)
               A_WORK: s_d.work = pwdata[7:0];
               A_OPND: s_d.opnd = pwdata[7:0];
               A_COND: s_d.cond = (s_q.cond & ~COND_SW_MASK)
                  | (pwdata[7:0] & COND_SW_MASK);
               A_ISPEED: s_d.ispd = pwdata[7:0] & SPD_MASK;
               A_VECTOR: s_d.vec = pwdata[15:0];
               A_CTRL: s_d.gie = pwdata[CTRL_GIE];
               A_APTR: begin
                  // Each byte lane lands in its own 8-bit register
                  for (int i = 0; i < 3; i++) begin
                     if (pstrb[i]) s_d.aptr[8*i +: 8] = pwdata[8*i +: 8];
                  end
               end
               A_DPTR: begin
                  for (int i = 0; i < 2; i++) begin
                     if (pstrb[i]) s_d.dptr[8*i +: 8] = pwdata[8*i +: 8];
                  end
               end
               default: begin
               end
            endcase
         end
         if (fire) begin
            // Flags not named by the command keep their value
            if (alu_w_we) s_d.work = alu_res;
            if (alu_hi_we) s_d.prodhi = alu_hi;
            if (alu_z_upd) s_d.cond[COND_Z] = alu_zero;
            if (alu_dc_upd) s_d.cond[COND_DIGIT] = alu_dc;
            if (alu_c_upd) s_d.cond[COND_CARRY] = alu_carry;
            if (cmd_op == OP_PAGE) begin
               s_d.cond[COND_PAGE_LSB +: PAGE_W] = cmd_imm[2:0];
            end
            if (cmd_op == OP_JUMP) begin
               s_d.jaddr = {s_q.cond[COND_PAGE_LSB +: PAGE_W],
                  cmd_tgt};
               s_d.jstb = 1'b1;
            end
            if (cmd_op == OP_SPEED) begin
               s_d.spd = cmd_imm & SPD_MASK;
            end
            if (cmd_op == OP_RETI && s_q.in_isr) begin
               // Page bits and speed come back from the shadows
               s_d.spd = s_q.sh_spd;
               s_d.cond[COND_PAGE_LSB +: PAGE_W] =
                  s_q.sh_cond[COND_PAGE_LSB +: PAGE_W];
               s_d.in_isr = 1'b0;
            end
         end
         if (take) begin
            // Entry swaps in the interrupt speed setting
            s_d.sh_cond = s_d.cond;
            s_d.sh_spd = s_q.spd;
            s_d.spd = s_q.ispd;
            s_d.cond[COND_PAGE_LSB +: PAGE_W] =
               s_q.vec[15 -: PAGE_W];
            s_d.in_isr = 1'b1;
         end
      end
   end

   // State register; the reset pin level idles high
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
         s_q.s1 <= PIN_IDLE;
         s_q.s2 <= PIN_IDLE;
         s_q.s3 <= PIN_IDLE;
         s_q.filt <= PIN_IDLE;
         s_q.spd <= SPD_RST;
         s_q.ispd <= SPD_RST;
         s_q.sh_spd <= SPD_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from state
   assign prdata = s_q.rdata;
   assign core_reset = s_q.core_rst;
   assign isr_active = s_q.in_isr;
   assign jump_addr = s_q.jaddr;
   assign jump_strobe = s_q.jstb;
   assign pll_disable = s_q.spd[SPD_PLL_DIS];
   assign main_crystal_disable_bit = s_q.spd[SPD_XTAL_DIS];
   assign primary_clock_block = s_q.spd[SPD_XTAL_DIS];
   assign system_source_select = s_q.spd[SPD_SRC_LSB +: 2];
   // Order is off, slow, crystal, multiplier
   assign source_onehot = {system_source_select == SRC_OFF,
      system_source_select == SRC_SLOW,
      system_source_select == SRC_XTAL,
      system_source_select == SRC_PLL};

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_zero_flag: assert property (
      fire && alu_z_upd && !rst_req |=>
      s_q.cond[COND_Z] == (s_q.work == 8'h00))
      else $error("zero flag does not match result");
   a_digit_add: assert property (
      fire && cmd_op == OP_ADD && !rst_req |=> s_q.cond[COND_DIGIT] ==
      (5'({1'b0, $past(s_q.work[3:0])}) + {1'b0, $past(s_q.opnd[3:0])}
      > 5'h0f))
      else $error("digit carry wrong after add");
   a_carry_sub: assert property (
      fire && cmd_op == OP_SUB && !rst_req |=> s_q.cond[COND_CARRY] ==
      ($past(s_q.work) >= $past(s_q.opnd)))
      else $error("carry wrong after subtract");
   a_rotate_carry: assert property (
      fire && cmd_op == OP_ROT_RIGHT && !rst_req |=>
      s_q.cond[COND_CARRY] == $past(s_q.work[0]) && s_q.work[7] ==
      $past(s_q.cond[COND_CARRY]))
      else $error("rotate right carry path wrong");
   a_wdog_cause: assert property (
      rst_req && !s_q.core_rst |=> s_q.core_rst &&
      s_q.cond[COND_WDOG] == $past(wdt_overflow))
      else $error("watchdog cause flag wrong at reset");
   a_lowsup_cause: assert property (
      rst_req && !s_q.core_rst && !s_q.filt[PIN_LSD] |=>
      !s_q.cond[COND_LOWSUP])
      else $error("brown-out cause flag set wrongly");
   a_page_jump: assert property (
      fire && cmd_op == OP_JUMP && !rst_req |=> jump_strobe &&
      jump_addr == {$past(s_q.cond[7:5]), $past(cmd_tgt)})
      else $error("jump address not formed from page bits");
   a_mul_split: assert property (
      fire && cmd_op == OP_MUL_U && !rst_req |=> {s_q.prodhi, s_q.work}
      == {8'h00, $past(s_q.work)} * {8'h00, $past(s_q.opnd)})
      else $error("product bytes misplaced");
   a_speed_hold: assert property (
      !(rst_req || take || (fire && (cmd_op == OP_SPEED ||
      cmd_op == OP_RETI))) |=> $stable(s_q.spd))
      else $error("speed setting changed without cause");
   a_isr_speed: assert property (
      take && !rst_req |=> isr_active && s_q.spd == $past(s_q.ispd))
      else $error("interrupt speed not applied on entry");
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
`default_nettype none
module tb
   import cfs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rv;
   logic [3:0] pstrb, source_onehot;
   logic reset_pin_n, low_supply_detect, wdt_overflow, debug_reset;
   logic core_reset, periph_irq, isr_active, jump_strobe, er;
   logic [7:0] ext_irq, im;
   logic [15:0] jump_addr;
   logic pll_disable, main_crystal_disable_bit, primary_clock_block;
   logic [1:0] system_source_select;
   int num_errors = 0;
   int total_checks = 0;
   int n;

   cfs_core i_cfs_core (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .reset_pin_n(reset_pin_n), .low_supply_detect(low_supply_detect),
      .wdt_overflow(wdt_overflow), .debug_reset(debug_reset),
      .core_reset(core_reset), .periph_irq(periph_irq), .ext_irq(ext_irq),
      .isr_active(isr_active), .jump_addr(jump_addr),
      .jump_strobe(jump_strobe), .pll_disable(pll_disable),
      .main_crystal_disable_bit(main_crystal_disable_bit),
      .primary_clock_block(primary_clock_block),
      .system_source_select(system_source_select),
      .source_onehot(source_onehot));

   // Free-running 125 MHz clock
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   task summarize;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   // One APB transfer; request held until pready is seen high
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
             input logic [3:0] s);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rv = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d,
           input logic [3:0] s = 4'hf);
      xfer(1'b1, a, d, s);
   endtask

   task rd(input logic [7:0] a);
      xfer(1'b0, a, 32'h0, 4'h0);
   endtask

   task cmd(input logic [3:0] o, input logic [7:0] i, input logic [12:0] t);
      wr(A_CMD, {3'b000, t, i, 4'h0, o});
   endtask

   // Load operands and carry, run one command, check result and flags
   task ar(input logic [3:0] o, input logic [7:0] w, b, input logic c,
           input logic [7:0] ew, input logic [2:0] ef, m);
      wr(A_WORK, 32'(w));
      wr(A_OPND, 32'(b));
      wr(A_COND, 32'(c));
      cmd(o, 8'h00, 13'h0);
      rd(A_WORK);
      chk(rv, 32'(ew));
      rd(A_COND);
      chk(rv & 32'(m), 32'(ef));
   endtask

   // Hold one reset source for 8 cycles, then read back the cause bits
   task rs(input int k, input logic [7:0] e);
      @(posedge pclk);
      case (k)
         0: wdt_overflow <= 1'b1;
         1: low_supply_detect <= 1'b1;
         2: debug_reset <= 1'b1;
         default: reset_pin_n <= 1'b0;
      endcase
      repeat (8) @(posedge pclk);
      chk(32'(core_reset), 32'h1);
      wdt_overflow <= 1'b0;
      low_supply_detect <= 1'b0;
      debug_reset <= 1'b0;
      reset_pin_n <= 1'b1;
      repeat (8) @(posedge pclk);
      chk(32'(core_reset), 32'h0);
      rd(A_COND);
      chk(rv, 32'(e));
   endtask

   // Hang guard: the whole run needs a few hundred cycles
   initial begin
      #100000;
      num_errors++;
      summarize;
   end

   initial begin
      {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      {low_supply_detect, wdt_overflow, debug_reset, periph_irq} = '0;
      ext_irq = 8'h00;
      reset_pin_n = 1'b1;
      presetn = 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rd(A_SPEED);
      chk(rv, 32'h0);
      wr(A_SPEED, 32'hf0);
      rd(A_SPEED);
      chk(rv, 32'h0);
      rd(8'h30);
      chk(rv, 32'h0);
      chk(32'(er), 32'h1);
      // Arithmetic flag table
      ar(OP_ADD, 8'h0f, 8'h01, 1'b0, 8'h10, 3'b010, 3'h7);
      ar(OP_ADD, 8'hff, 8'h01, 1'b0, 8'h00, 3'b111, 3'h7);
      ar(OP_SUB, 8'h10, 8'h01, 1'b0, 8'h0f, 3'b001, 3'h7);
      ar(OP_SUB, 8'h00, 8'h01, 1'b0, 8'hff, 3'b000, 3'h7);
      ar(OP_SUB, 8'h33, 8'h33, 1'b0, 8'h00, 3'b111, 3'h7);
      ar(OP_XOR, 8'h5a, 8'h5a, 1'b1, 8'h00, 3'b101, 3'h7);
      ar(OP_ROT_RIGHT, 8'h81, 8'h00, 1'b0, 8'h40, 3'b001, 3'h1);
      ar(OP_ROT_LEFT, 8'h80, 8'h00, 1'b1, 8'h01, 3'b001, 3'h1);
      ar(OP_MUL_U, 8'hff, 8'h02, 1'b0, 8'hfe, 3'b000, 3'h7);
      rd(A_PRODHI);
      chk(rv, 32'h01);
      ar(OP_MUL_S, 8'hff, 8'h02, 1'b1, 8'hfe, 3'b001, 3'h7);
      rd(A_PRODHI);
      chk(rv, 32'hff);
      // Every clock source code, disable bits toggled alongside
      for (int i = 0; i < 4; i++) begin
         im = {i[0], ~i[0], i[1:0], 4'hf};
         cmd(OP_SPEED, im, 13'h0);
         repeat (2) @(posedge pclk);
         #1;
         chk(32'(pll_disable), 32'(i[0]));
         chk(32'({main_crystal_disable_bit, primary_clock_block}),
             32'({2{~i[0]}}));
         chk(32'(system_source_select), 32'(i));
         chk(32'(source_onehot), 32'(1 << i));
         rd(A_SPEED);
         chk(rv, 32'(im & 8'hf0));
      end
      // Byte lanes select which pointer bytes change
      wr(A_APTR, 32'h00aabbcc, 4'b0101);
      rd(A_APTR);
      chk(rv, 32'h00aa00cc);
      wr(A_DPTR, 32'h1234, 4'b0010);
      rd(A_DPTR);
      chk(rv, 32'h1200);
      cmd(OP_PAGE, 8'h05, 13'h0);
      cmd(OP_JUMP, 8'h00, 13'h1abc);
      #1;
      chk(32'(jump_addr), 32'({3'd5, 13'h1abc}));
      chk(32'(jump_strobe), 32'h1);
      // Interrupt swaps in its own speed and the vector page
      cmd(OP_SPEED, 8'h80, 13'h0);
      cmd(OP_PAGE, 8'h02, 13'h0);
      wr(A_ISPEED, 32'h4f);
      wr(A_VECTOR, 32'ha000);
      wr(A_CTRL, 32'h1);
      @(posedge pclk);
      periph_irq <= 1'b1;
      n = 0;
      while (isr_active !== 1'b1 && n < 20) begin
         @(posedge pclk);
         n++;
      end
      periph_irq <= 1'b0;
      chk(32'(isr_active), 32'h1);
      rd(A_SPEED);
      chk(rv, 32'h40);
      rd(A_COND);
      chk(32'(rv[7:5]), 32'h5);
      cmd(OP_RETI, 8'h00, 13'h0);
      rd(A_SPEED);
      chk(rv, 32'h80);
      rd(A_COND);
      chk(32'(rv[7:5]), 32'h2);
      chk(32'(isr_active), 32'h0);
      // An external pin raises an interrupt through its filter
      @(posedge pclk);
      ext_irq <= 8'h04;
      n = 0;
      while (isr_active !== 1'b1 && n < 20) begin
         @(posedge pclk);
         n++;
      end
      ext_irq <= 8'h00;
      chk(32'(isr_active), 32'h1);
      rd(A_COND);
      chk(32'(rv[7:5]), 32'h5);
      // Let the pin filter drop before returning, or it re-enters
      repeat (6) @(posedge pclk);
      cmd(OP_RETI, 8'h00, 13'h0);
      rd(A_SPEED);
      chk(rv, 32'h80);
      chk(32'(isr_active), 32'h0);
      // Cause flags after each reset source: watchdog, low supply, debug, reset pin
      rs(0, 8'h10);
      rs(1, 8'h08);
      rs(2, 8'h00);
      rs(3, 8'h00);
      summarize;
   end
endmodule
`default_nettype wire
